// ### design/svm_pkg.sv
// Constants, field layout and timing counts of the supply monitor front end.
// Assumes a single 50 MHz system clock; the master and array clocks are derived.
//
// Function
// - Six independent channels, each with own trip comparator, filter and configuration.
// - Trip point from coarse code 4..f and fine code 10..1f, 192 points.
// - Channel output high when input is above threshold, low otherwise.
// - Rising supply sets output only when the rising trip level is crossed.
// - Falling supply clears output only at the lower falling trip level.
// - Hysteresis gap follows coarse range, 8 mV lowest up to 60 mV highest.
// - Selectable 75 mV ground detect threshold, applied without any hysteresis.
// - Filter enabled delays a comparator decision by 48 us.
// - Filter disabled delays a comparator decision by 12 us.
// - Channel outputs always sampled on the logic array clock.
// - Logic array clock is the 8 MHz master clock divided by 32.
// - Comparator state and filters run on the master clock.
package svm_pkg;

  localparam int          NUM_CH        = 6;
  localparam int          CLK_MHZ       = 50;
  localparam int          MCLK_MHZ      = 8;
  localparam logic [5:0]  ACC_STEP      = 6'(MCLK_MHZ);
  localparam logic [5:0]  ACC_MOD       = 6'(CLK_MHZ);
  localparam logic [4:0]  LA_DIV_LAST   = 5'h1f;
  localparam int          LA_PERIOD_CYC = 200;

  localparam int          FILT_ON_NS    = 48000;
  localparam int          FILT_OFF_NS   = 12000;
  localparam logic [8:0]  FILT_ON_TICKS = 9'(FILT_ON_NS * MCLK_MHZ / 1000);
  localparam logic [8:0]  FILT_OFF_TICKS = 9'(FILT_OFF_NS * MCLK_MHZ / 1000);

  localparam logic [7:0]  CFG_BASE      = 8'h00;
  localparam logic [7:0]  STATUS_ADDR   = 8'h20;
  localparam logic [7:0]  EVENT_ADDR    = 8'h24;

  localparam int          COARSE_LSB    = 0;
  localparam int          FINE_LSB      = 4;
  localparam int          FINE_TOP      = 8;
  localparam int          ZERO_BIT      = 9;
  localparam int          FEN_BIT       = 10;
  localparam int          OV_BIT        = 11;
  localparam logic [3:0]  COARSE_MIN    = 4'h4;
  localparam logic [11:0] CFG_RST       = 12'h50f;

  localparam int          STAT_FILT_LSB = 8;
  localparam int          STAT_HYST_LSB = 16;
  localparam int          EVT_FALL_LSB  = 8;

endpackage : svm_pkg

// ### design/svm_tick_if.sv
// Timing strobes shared by the clock divider and the channel filters.
// Both strobes are one system cycle long and synchronous to i_clk.
`timescale 1ns/1ps
interface svm_tick_if;
  logic master_tick;
  logic la_tick;
  modport src (output master_tick, output la_tick);
  modport snk (input master_tick, input la_tick);
endinterface : svm_tick_if

// ### design/svm_clkgen.sv
// Master clock and logic array clock strobes derived from the system clock.
// Assumes i_clk at 50 MHz; the accumulator gives an exact 8 MHz average rate.
`timescale 1ns/1ps
module svm_clkgen (
  // Clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_resetn,
  // Strobes out
  svm_tick_if.src     tick
);

  logic [5:0] acc_reg;
  logic [4:0] div_reg;
  logic       mtick_reg;
  logic       latick_reg;
  logic [5:0] acc_sum;

  assign acc_sum = acc_reg + svm_pkg::ACC_STEP;

  // Fractional divider; jitter of one system cycle is far below a filter step
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg   <= 6'h00;
      mtick_reg <= 1'b0;
    end else if (acc_sum >= svm_pkg::ACC_MOD) begin
      acc_reg   <= acc_sum - svm_pkg::ACC_MOD;
      mtick_reg <= 1'b1;
    end else begin
      acc_reg   <= acc_sum;
      mtick_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg    <= 5'h00;
      latick_reg <= 1'b0;
    end else begin
      latick_reg <= mtick_reg && (div_reg == svm_pkg::LA_DIV_LAST);
      if (mtick_reg) begin
        div_reg <= div_reg + 5'h01;
      end
    end
  end

  assign tick.master_tick = mtick_reg;
  assign tick.la_tick     = latick_reg;

  logic [7:0] gap_cnt;
  logic       gap_seen;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_cnt  <= 8'h00;
      gap_seen <= 1'b0;
    end else if (latick_reg) begin
      gap_cnt  <= 8'h01;
      gap_seen <= 1'b1;
    end else if (gap_cnt != 8'hff) begin
      gap_cnt <= gap_cnt + 8'h01;
    end
  end

  la_period_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (latick_reg && gap_seen) |-> (gap_cnt == 8'(svm_pkg::LA_PERIOD_CYC)))
    else $error("logic array strobe period wrong");

endmodule : svm_clkgen

// ### design/svm_chan_filter.sv
// One monitor channel: comparator hysteresis state and the glitch filter.
// Assumes the analog side supplies three comparator levels for the channel.
`timescale 1ns/1ps
module svm_chan_filter (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  svm_tick_if.snk   tick,
  // Comparator levels
  input  wire logic i_rise,
  input  wire logic i_fall,
  input  wire logic i_zero,
  // Configuration
  input  wire logic i_zero_sel,
  input  wire logic i_filt_en,
  // Results
  output logic      o_hyst_state,
  output logic      o_level
);

  logic       hyst_reg;
  logic       level_reg;
  logic [8:0] stable_cnt;
  logic [8:0] win;

  assign win = i_filt_en ? svm_pkg::FILT_ON_TICKS : svm_pkg::FILT_OFF_TICKS;

  // Comparator decision taken on master clock
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hyst_reg <= 1'b0;
    end else if (tick.master_tick) begin
      if (i_zero_sel) begin
        hyst_reg <= i_zero;
      end else if (!hyst_reg) begin
        hyst_reg <= i_rise;
      end else begin
        hyst_reg <= i_fall;
      end
    end
  end

  // Level must hold for the whole window before it passes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stable_cnt <= 9'h000;
      level_reg  <= 1'b0;
    end else if (hyst_reg == level_reg) begin
      stable_cnt <= 9'h000;
    end else if (tick.master_tick) begin
      if (stable_cnt >= win - 9'h001) begin
        stable_cnt <= 9'h000;
        level_reg  <= hyst_reg;
      end else begin
        stable_cnt <= stable_cnt + 9'h001;
      end
    end
  end

  assign o_hyst_state = hyst_reg;
  assign o_level      = level_reg;

  hyst_rise_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ($rose(hyst_reg) && !$past(i_zero_sel)) |-> $past(i_rise))
    else $error("set without rising trip");

  hyst_fall_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    ($fell(hyst_reg) && !$past(i_zero_sel)) |-> !$past(i_fall))
    else $error("clear above falling trip");

  zero_nohyst_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (tick.master_tick && i_zero_sel) |=> (hyst_reg == $past(i_zero)))
    else $error("zero detect not direct");

  filt_window_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $changed(level_reg) |-> ($past(tick.master_tick) && $past(stable_cnt) == $past(win) - 9'h001))
    else $error("filter passed early");

  filt_sel_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_filt_en |-> (win == 9'd384))
    else $error("filter on window wrong");

  filt_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !i_filt_en |-> (win == 9'd96))
    else $error("filter off window wrong");

endmodule : svm_chan_filter

// ### design/svm_front_end.sv
// Top of the six-channel supply monitor front end with its register port.
// Assumes external comparators for rising, falling and 75 mV levels per channel,
// and a register master that keeps strobes one cycle long and never overlapping.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module svm_front_end (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [31:0] o_rd_data,
  // Comparator levels, monitored_supply_input above each trip
  input  wire logic [5:0]  i_cmp_rise,
  input  wire logic [5:0]  i_cmp_fall,
  input  wire logic [5:0]  i_cmp_zero,
  // Analog trip control
  output logic [5:0][8:0]  o_trip_select_code,
  output logic [5:0]       o_trip_set_ov,
  output logic [5:0]       o_zero_detect_sel,
  output logic [5:0][5:0]  o_hyst_mv,
  // Logic array side
  output logic [5:0]       o_channel_out,
  output logic             o_logic_array_clock
);

  // Gap of the comparator in mV for a coarse range
  function automatic logic [5:0] svm_gap_mv(input logic [3:0] coarse, input logic zero);
    logic [5:0] gap;
    case (coarse)
      4'hf:    gap = 6'h08;
      4'he:    gap = 6'h0a;
      4'hd:    gap = 6'h0c;
      4'hc:    gap = 6'h0e;
      4'hb:    gap = 6'h11;
      4'ha:    gap = 6'h13;
      4'h9:    gap = 6'h17;
      4'h8:    gap = 6'h1c;
      4'h7:    gap = 6'h21;
      4'h6:    gap = 6'h27;
      4'h5:    gap = 6'h32;
      4'h4:    gap = 6'h3c;
      default: gap = 6'h00;
    endcase
    return zero ? 6'h00 : gap;
  endfunction : svm_gap_mv

  // Channel index of a configuration word, or 7 when not one
  function automatic logic [2:0] svm_cfg_ch(input logic [7:0] addr);
    logic [2:0] ch;
    ch = 3'h7;
    if (addr[1:0] == 2'h0 && addr >= svm_pkg::CFG_BASE
        && addr < svm_pkg::CFG_BASE + 8'(4 * svm_pkg::NUM_CH)) begin
      ch = 3'(addr[4:2] - svm_pkg::CFG_BASE[4:2]);
    end
    return ch;
  endfunction : svm_cfg_ch

  svm_tick_if tick ();

  svm_clkgen u_clkgen (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .tick     (tick)
  );

  logic [5:0][11:0] cfg_reg;
  logic [5:0][5:0]  hyst_mv_reg;
  logic [5:0]       chan_out_reg;
  logic [5:0]       chan_out_next;
  logic [5:0]       filt_level;
  logic [5:0]       hyst_state;
  logic [11:0]      evt_reg;
  logic [31:0]      rd_data_reg;
  logic             la_clk_reg;
  logic [2:0]       wr_ch;
  logic [2:0]       rd_ch;
  logic [3:0]       wr_coarse;
  logic             wr_fine_ok;

  assign wr_ch      = svm_cfg_ch(i_addr);
  assign rd_ch      = wr_ch;
  assign wr_coarse  = i_wr_data[svm_pkg::COARSE_LSB +: 4];
  assign wr_fine_ok = i_wr_data[svm_pkg::FINE_TOP];

  // Per-channel configuration; an out-of-range trip code leaves the old one
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_reg <= {svm_pkg::NUM_CH{svm_pkg::CFG_RST}};
    end else if (i_wr_en && wr_ch != 3'h7) begin
      cfg_reg[wr_ch][svm_pkg::OV_BIT:svm_pkg::ZERO_BIT]
        <= i_wr_data[svm_pkg::OV_BIT:svm_pkg::ZERO_BIT];
      if (wr_coarse >= svm_pkg::COARSE_MIN && wr_fine_ok) begin
        cfg_reg[wr_ch][svm_pkg::FINE_TOP:0] <= i_wr_data[svm_pkg::FINE_TOP:0];
      end
    end
  end

  // Gap follows the stored range one cycle after the trip code, so the analog side sees a stale pair for that cycle
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hyst_mv_reg <= '0;
    end else begin
      for (int c = 0; c < svm_pkg::NUM_CH; c++) begin
        hyst_mv_reg[c] <= svm_gap_mv(cfg_reg[c][svm_pkg::COARSE_LSB +: 4],
                                     cfg_reg[c][svm_pkg::ZERO_BIT]);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < svm_pkg::NUM_CH; g++) begin : g_chan
      svm_chan_filter u_filter (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .tick         (tick),
        .i_rise       (i_cmp_rise[g]),
        .i_fall       (i_cmp_fall[g]),
        .i_zero       (i_cmp_zero[g]),
        .i_zero_sel   (cfg_reg[g][svm_pkg::ZERO_BIT]),
        .i_filt_en    (cfg_reg[g][svm_pkg::FEN_BIT]),
        .o_hyst_state (hyst_state[g]),
        .o_level      (filt_level[g])
      );
      assign o_trip_select_code[g] = cfg_reg[g][svm_pkg::FINE_TOP:0];
      assign o_trip_set_ov[g]      = cfg_reg[g][svm_pkg::OV_BIT];
      assign o_zero_detect_sel[g]  = cfg_reg[g][svm_pkg::ZERO_BIT];
    end
  endgenerate

  // Registered into the array domain only on its clock strobe
  assign chan_out_next = tick.la_tick ? filt_level : chan_out_reg;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      chan_out_reg <= 6'h00;
    end else begin
      chan_out_reg <= chan_out_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      la_clk_reg <= 1'b0;
    end else begin
      la_clk_reg <= tick.la_tick;
    end
  end

  // Edge events; a new edge in the clearing cycle stays set
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      evt_reg <= 12'h000;
    end else begin
      evt_reg <= (evt_reg & ~((i_wr_en && i_addr == svm_pkg::EVENT_ADDR)
                              ? i_wr_data[11:0] : 12'h000))
               | {chan_out_reg & ~chan_out_next, chan_out_next & ~chan_out_reg};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (!i_rd_en) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (rd_ch != 3'h7) begin
      rd_data_reg <= {20'h00000, cfg_reg[rd_ch]};
    end else if (i_addr == svm_pkg::STATUS_ADDR) begin
      rd_data_reg <= {10'h000, hyst_state, 2'h0, filt_level, 2'h0, chan_out_reg};
    end else if (i_addr == svm_pkg::EVENT_ADDR) begin
      rd_data_reg <= {16'h0000, 2'h0, evt_reg[11:6], 2'h0, evt_reg[5:0]};
    end else begin
      rd_data_reg <= 32'h0000_0000;
    end
  end

  assign o_rd_data           = rd_data_reg;
  assign o_hyst_mv           = hyst_mv_reg;
  assign o_channel_out       = chan_out_reg;
  assign o_logic_array_clock = la_clk_reg;

  sync_la_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $changed(chan_out_reg) |-> ($past(tick.la_tick) && chan_out_reg == $past(filt_level)))
    else $error("channel output moved off the array clock");

  out_low_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(chan_out_reg[2]) |-> $past(filt_level[2]))
    else $error("channel output high without qualified sample");

  coarse_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cfg_reg[0][3:0] >= svm_pkg::COARSE_MIN) && cfg_reg[0][svm_pkg::FINE_TOP])
    else $error("illegal trip code stored");

  gap_range_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (cfg_reg[0][3:0] == 4'hf && !cfg_reg[0][svm_pkg::ZERO_BIT]) |=> (o_hyst_mv[0] == 6'h08))
    else $error("lowest range gap not 8 mV");

  gap_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    cfg_reg[4][svm_pkg::ZERO_BIT] |=> (o_hyst_mv[4] == 6'h00))
    else $error("hysteresis on zero detect");

endmodule : svm_front_end

// ### sim/svm_rail_model.sv
// Behavioural supply rails and the three comparators of each channel.
// Assumes every rising trip sits at TRIP_MV; the gap comes from the device.
`timescale 1ns/1ps
module svm_rail_model #(
  parameter int TRIP_MV = 1000
) (
  // Rail levels and gap
  input  wire logic [5:0][12:0] i_rail_mv,
  input  wire logic [5:0][5:0]  i_hyst_mv,
  // Comparator levels
  output logic      [5:0]       o_cmp_rise,
  output logic      [5:0]       o_cmp_fall,
  output logic      [5:0]       o_cmp_zero
);
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      o_cmp_rise[i] = int'(i_rail_mv[i]) > TRIP_MV;
      o_cmp_fall[i] = int'(i_rail_mv[i]) > TRIP_MV - int'(i_hyst_mv[i]);
      o_cmp_zero[i] = int'(i_rail_mv[i]) > 75;
    end
  end
endmodule : svm_rail_model

// ### sim/svm_front_end_test.sv
// Self-checking bench of the supply monitor front end.
// Assumes the rail model drives every comparator input of the device.
`timescale 1ns/1ps
module svm_front_end_test;
  logic             i_clk = 1'b0;
  logic             i_resetn = 1'b0;
  logic [7:0]       i_addr = 8'h00;
  logic [31:0]      i_wr_data = 32'h0;
  logic             i_wr_en = 1'b0;
  logic             i_rd_en = 1'b0;
  logic [31:0]      o_rd_data;
  logic [5:0]       cmp_rise;
  logic [5:0]       cmp_fall;
  logic [5:0]       cmp_zero;
  logic [5:0][8:0]  o_trip_select_code;
  logic [5:0]       o_trip_set_ov;
  logic [5:0]       o_zero_detect_sel;
  logic [5:0][5:0]  o_hyst_mv;
  logic [5:0]       o_channel_out;
  logic             o_logic_array_clock;
  logic [5:0][12:0] rail_mv = '0;
  int               failures = 0;
  int               tests_run = 0;
  int               n;
  localparam int    GAP [12] = '{8, 10, 12, 14, 17, 19, 23, 28, 33, 39, 50, 60};

  always #10 i_clk = ~i_clk;

  svm_front_end DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .i_cmp_rise(cmp_rise), .i_cmp_fall(cmp_fall), .i_cmp_zero(cmp_zero),
    .o_trip_select_code(o_trip_select_code), .o_trip_set_ov(o_trip_set_ov),
    .o_zero_detect_sel(o_zero_detect_sel), .o_hyst_mv(o_hyst_mv),
    .o_channel_out(o_channel_out), .o_logic_array_clock(o_logic_array_clock));

  svm_rail_model rails (.i_rail_mv(rail_mv), .i_hyst_mv(o_hyst_mv),
    .o_cmp_rise(cmp_rise), .o_cmp_fall(cmp_fall), .o_cmp_zero(cmp_zero));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    #1;
    chk(what, exp, o_rd_data);
  endtask : rd_chk

  task automatic set_rail(input int ch, input int mv);
    @(posedge i_clk);
    rail_mv[ch] <= 13'(mv);
    #1;
  endtask : set_rail

  // Latency window also covers the wait for the next array strobe
  task automatic wait_out(input int ch, input logic val, input int lo, input int hi);
    logic la_prev;
    n = 0;
    la_prev = 1'b0;
    while (o_channel_out[ch] !== val && n <= hi) begin
      la_prev = o_logic_array_clock;
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("latency in range", 32'(n >= lo && n <= hi), 32'h1);
    chk("change at array strobe", 32'(la_prev | o_logic_array_clock), 32'h1);
  endtask : wait_out

  task automatic hold(input int ch, input logic val, input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge i_clk);
      #1;
      if (o_channel_out[ch] !== val) n++;
    end
    chk("output held", 32'(n), 32'h0);
  endtask : hold

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #(40000 * 20);
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("channel_out", 32'h0, 32'(o_channel_out));
    chk("trip code", 32'h10f, 32'(o_trip_select_code[0]));
    rd_chk("cfg reset", 8'h00, 32'h50f);
    chk("gap", 32'd8, 32'(o_hyst_mv[5]));
    $display("test reset done");
    // Two passes set all twelve coarse codes across the six channels
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++)
        wr(8'(4 * i), 32'((16 + i) << 4 | (4 + i + 6 * p) | (i % 2) << 11));
      for (int i = 0; i < 6; i++) begin
        rd_chk("cfg", 8'(4 * i), 32'((16 + i) << 4 | (4 + i + 6 * p) | (i % 2) << 11));
        chk("trip code", 32'((16 + i) << 4 | (4 + i + 6 * p)), 32'(o_trip_select_code[i]));
        chk("ov set", 32'(i % 2), 32'(o_trip_set_ov[i]));
        chk("gap", 32'(GAP[11 - i - 6 * p]), 32'(o_hyst_mv[i]));
      end
    end
    wr(8'h00, 32'h113);
    rd_chk("cfg bad coarse", 8'h00, 32'h10a);
    wr(8'h08, 32'h10f);
    wr(8'h0c, 32'h50f);
    wr(8'h10, 32'h214);
    rd_chk("unmapped", 8'h40, 32'h0);
    chk("zero sel", 32'h1, 32'(o_zero_detect_sel[4]));
    chk("zero gap", 32'h0, 32'(o_hyst_mv[4]));
    $display("test config done");
    set_rail(2, 1005);
    wait_out(2, 1'b1, 590, 820);
    rd_chk("status", 8'h20, 32'h040404);
    rd_chk("events", 8'h24, 32'h4);
    wr(8'h24, 32'h4);
    rd_chk("events cleared", 8'h24, 32'h0);
    set_rail(2, 995);
    hold(2, 1'b1, 900);
    set_rail(2, 990);
    wait_out(2, 1'b0, 590, 820);
    set_rail(2, 995);
    hold(2, 1'b0, 900);
    $display("test hysteresis done");
    set_rail(3, 1005);
    repeat (1000) @(posedge i_clk);
    set_rail(3, 0);
    hold(3, 1'b0, 2700);
    set_rail(3, 1005);
    wait_out(3, 1'b1, 2390, 2620);
    $display("test filter done");
    set_rail(4, 100);
    wait_out(4, 1'b1, 590, 820);
    set_rail(4, 70);
    wait_out(4, 1'b0, 590, 820);
    $display("test zero detect done");
    n = 0;
    while (o_logic_array_clock !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_logic_array_clock !== 1'b1 && n < 300);
    chk("array period", 32'(n), 32'd200);
    $display("test array clock done");
    final_report();
  end
endmodule : svm_front_end_test
